// ---- bench/tsl_limiter_chk.sv ----
// Concurrent checks on the speed limiter ports
`timescale 1ns/1ns
`default_nettype none
`include "tsl_regs.svh"
module tsl_limiter_chk #(
    parameter int TICK_CYCLES = 10000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_limit_source_select,
    input wire logic [15:0] i_fixed_forward_limit,
    input wire logic [15:0] i_max_frequency,
    input wire logic [15:0] i_min_frequency,
    input wire logic [15:0] i_starting_frequency,
    input wire logic signed [15:0] i_torque_command,
    input wire logic signed [15:0] i_actual_speed,
    input wire logic [7:0] i_output_terminal_function,
    input wire logic [7:0] i_input_terminal_function,
    input wire logic i_input_terminal_level,
    input wire logic i_encoder_vector,
    input wire logic [15:0] i_current_p_gain_primary,
    input wire logic [15:0] i_current_i_time_primary,
    input wire logic [15:0] i_current_p_gain_secondary,
    input wire logic [15:0] i_current_i_time_secondary,
    input wire logic signed [16:0] o_speed_limit,
    input wire logic o_limit_active_out,
    input wire logic o_limit_active_display,
    input wire logic o_speed_regulation,
    input wire logic [15:0] o_p_gain_pct,
    input wire logic [15:0] o_i_time_ms,
    input wire logic [31:0] o_p_gain_rad_s
);
    logic sec_on;
    logic fix_on;
    logic [15:0] fwd;
    logic [16:0] lim_abs;
    assign sec_on = i_input_terminal_function == `TSL_IN_FUNC_SECOND && i_input_terminal_level;
    assign fix_on = i_limit_source_select && i_actual_speed == 16'sh0000;
    assign fwd = i_fixed_forward_limit;
    assign lim_abs = o_speed_limit[16] ? -o_speed_limit : o_speed_limit;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    // ----
    // Outputs load one edge after their inputs; $past guards reset edges
    // ----
    gain_scale_a: assert property ($past(i_rst_b) |-> o_p_gain_rad_s ==
        o_p_gain_pct * ($past(i_encoder_vector) ? 32'hE : 32'hA)) else $error("rad/s scale");
    sec_gain_a: assert property ($past(i_rst_b && sec_on && i_current_p_gain_primary <= 16'h1F4
        && i_current_p_gain_secondary <= 16'h1F4) |-> o_p_gain_pct ==
        $past(i_current_p_gain_secondary)) else $error("secondary gain");
    prim_gain_a: assert property ($past(i_rst_b && !sec_on && i_current_p_gain_primary
        <= 16'h1F4) |-> o_p_gain_pct == $past(i_current_p_gain_primary)) else $error("primary gain");
    sec_time_a: assert property ($past(i_rst_b && sec_on && i_current_i_time_primary <= 16'h1F4)
        |-> o_i_time_ms == $past(i_current_i_time_secondary <= 16'h1F4 ?
        i_current_i_time_secondary : i_current_i_time_primary)) else $error("secondary time");
    out_pol_a: assert property ($past(i_rst_b) |-> o_limit_active_out ==
        ($past(i_output_terminal_function) == `TSL_OUT_FUNC_POS ? o_limit_active_display :
        $past(i_output_terminal_function) == `TSL_OUT_FUNC_NEG && !o_limit_active_display))
        else $error("terminal polarity");
    spd_reg_a: assert property (o_speed_regulation == o_limit_active_display)
        else $error("regulation flag");
    fix_sign_a: assert property ($past(i_rst_b && fix_on) |-> ($past(i_torque_command[15]) ?
        o_speed_limit[16] || o_speed_limit == 17'h0 : !o_speed_limit[16])) else $error("sign");
    fix_val_a: assert property ($past(i_rst_b && fix_on && i_starting_frequency <= fwd &&
        i_min_frequency <= fwd && fwd <= i_max_frequency && fwd <= 16'h9C40) |->
        lim_abs == $past({1'b0, fwd})) else $error("fixed limit");
    max_clamp_a: assert property ($past(i_rst_b && fix_on && fwd > i_max_frequency &&
        fwd <= 16'h9C40 && i_min_frequency <= i_max_frequency && i_starting_frequency <= fwd)
        |-> lim_abs == $past({1'b0, i_max_frequency})) else $error("max clamp");
    start_zero_a: assert property ($past(i_rst_b && fix_on && fwd < i_starting_frequency)
        |-> o_speed_limit == 17'h0) else $error("start zero");
    act_c: cover property (o_limit_active_display && i_limit_source_select);
    rev_c: cover property (o_speed_limit[16] && i_actual_speed != 16'sh0000);
    sec_c: cover property (sec_on && i_encoder_vector);
endmodule : tsl_limiter_chk
bind tsl_limiter tsl_limiter_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.*);
`default_nettype wire

// ---- bench/tsl_limiter_tb_top.sv ----
// Directed testbench for the torque-mode speed limiter
`timescale 1ns/1ns
`default_nettype none
module tsl_limiter_tb_top;
    logic i_ref_clk, i_rst_b, i_limit_source_select, i_start_in, i_second_accel_sel, wr;
    logic i_multispeed_high_in, i_multispeed_mid_in, i_multispeed_low_in;
    logic i_input_terminal_level, i_encoder_vector, o_limit_active_out;
    logic o_limit_active_display, o_speed_regulation;
    logic [2:0] ms;
    logic [3:0] idx;
    logic [15:0] val, o_p_gain_pct, o_i_time_ms;
    logic [15:0] prm [16];
    logic [15:0] i_fixed_forward_limit, i_reverse_side_limit, i_max_frequency, i_min_frequency;
    logic [15:0] i_starting_frequency, i_accel_time, i_decel_time, i_accel_time_second;
    logic [15:0] i_decel_time_second, i_dc_brake_start_freq, i_current_p_gain_primary;
    logic [15:0] i_current_i_time_primary, i_current_p_gain_secondary;
    logic [15:0] i_current_i_time_secondary, i_speed_command, i_multispeed_setting;
    logic signed [15:0] i_torque_command, i_actual_speed;
    logic [7:0] i_output_terminal_function, i_input_terminal_function;
    logic signed [16:0] o_speed_limit;
    logic [31:0] o_p_gain_rad_s;
    logic signed [15:0] tq [3] = '{-16'sh0064, 16'sh0000, 16'sh0064};
    logic [7:0] fn [3] = '{8'h03, 8'h67, 8'h00};
    int n_mismatch, checked, cyc;
    assign {i_multispeed_high_in, i_multispeed_mid_in, i_multispeed_low_in} = ms;
    assign {i_fixed_forward_limit, i_reverse_side_limit, i_max_frequency} = {prm[0], prm[1], prm[2]};
    assign {i_min_frequency, i_starting_frequency, i_accel_time} = {prm[3], prm[4], prm[5]};
    assign {i_decel_time, i_accel_time_second, i_decel_time_second} = {prm[6], prm[7], prm[8]};
    assign {i_dc_brake_start_freq, i_current_p_gain_primary} = {prm[9], prm[10]};
    assign {i_current_i_time_primary, i_current_p_gain_secondary} = {prm[11], prm[12]};
    assign {i_current_i_time_secondary, i_speed_command} = {prm[13], prm[14]};
    assign i_multispeed_setting = prm[15];
    // Short tick keeps ramps to a few hundred cycles at most
    tsl_limiter #(.TICK_CYCLES(10)) DUT (.*);
    tsl_param_store u_prm (.i_ref_clk(i_ref_clk), .i_rst_b(i_rst_b), .i_wr(wr), .i_idx(idx),
        .i_val(val), .o_prm(prm));
    initial i_ref_clk = 1'b0;
    always #50 i_ref_clk = ~i_ref_clk;
    // ----
    // Access tasks
    // ----
    task automatic summarize;
        $display("checks %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic chk(input string what, input logic signed [31:0] seen,
                       input logic signed [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value %s expected %0d seen %0d", what, exp, seen);
        end
    endtask : chk
    task automatic look;
        repeat (3) @(posedge i_ref_clk);
        #10;
    endtask : look
    task automatic setp(input logic [3:0] k, input logic [15:0] v);
        @(posedge i_ref_clk);
        wr <= 1'b1;
        idx <= k;
        val <= v;
        @(posedge i_ref_clk);
        wr <= 1'b0;
    endtask : setp
    function automatic logic signed [31:0] get(input int sel);
        case (sel)
            0: get = o_speed_limit;
            1: get = o_p_gain_pct;
            2: get = o_i_time_ms;
            default: get = o_p_gain_rad_s;
        endcase
    endfunction : get
    task automatic pchk(input string what, input logic [3:0] k, input logic [15:0] v,
                        input int sel, input logic signed [31:0] exp, input logic [15:0] rs);
        setp(k, v);
        look();
        chk(what, get(sel), exp);
        setp(k, rs);
        look();
    endtask : pchk
    // Bounded wait; a miss ends the run
    task automatic wait_lim(input string what, input logic signed [16:0] exp, input int bound);
        #10;
        cyc = 0;
        while (o_speed_limit !== exp && cyc < bound) begin
            @(posedge i_ref_clk);
            #10;
            cyc++;
        end
        chk(what, o_speed_limit, exp);
        if (o_speed_limit !== exp) summarize();
    endtask : wait_lim
    // ----
    // Tests
    // ----
    initial begin
        {i_rst_b, i_limit_source_select, i_start_in, i_second_accel_sel, wr} = 5'h08;
        {i_input_terminal_level, i_encoder_vector, ms, idx, val} = 25'h0;
        {i_torque_command, i_actual_speed} = 32'h0064_0000;
        {i_output_terminal_function, i_input_terminal_function} = 16'h0300;
        repeat (5) @(posedge i_ref_clk);
        #10;
        chk("reset limit", o_speed_limit, 32'sh0);
        chk("reset gain", o_p_gain_pct, 32'sh64);
        chk("reset time", o_i_time_ms, 32'sh5);
        chk("reset rad", o_p_gain_rad_s, 32'sh3E8);
        @(posedge i_ref_clk);
        i_rst_b <= 1'b1;
        look();
        $display("test reset done");
        for (int k = 0; k < 3; k++) begin
            @(posedge i_ref_clk);
            i_torque_command <= tq[k];
            look();
            chk("sign", o_speed_limit, k == 0 ? -32'sh1770 : 32'sh1770);
        end
        $display("test sign done");
        pchk("max clamp", 4'h2, 16'h1388, 0, 32'sh1388, 16'h9C40);
        pchk("min clamp", 4'h3, 16'h1B58, 0, 32'sh1B58, 16'h0000);
        pchk("start zero", 4'h4, 16'h1B58, 0, 32'sh0, 16'h0000);
        pchk("fwd sat", 4'h0, 16'hFFFF, 0, 32'sh9C40, 16'h1770);
        $display("test clamp done");
        @(posedge i_ref_clk);
        i_actual_speed <= -16'sh0064;
        look();
        chk("rev unset", o_speed_limit, -32'sh1770);
        chk("idle flag", o_limit_active_display, 32'sh0);
        pchk("rev limit", 4'h1, 16'h0BB8, 0, -32'sh0BB8, 16'h0BB8);
        @(posedge i_ref_clk);
        i_actual_speed <= -16'sh0BB8;
        look();
        chk("panel flag", o_limit_active_display, 32'sh1);
        chk("regulation", o_speed_regulation, 32'sh1);
        for (int k = 0; k < 3; k++) begin
            @(posedge i_ref_clk);
            i_output_terminal_function <= fn[k];
            look();
            chk("terminal", o_limit_active_out, k == 0);
        end
        @(posedge i_ref_clk);
        i_actual_speed <= 16'sh0000;
        $display("test reverse done");
        setp(4'hC, 16'h00C8);
        i_input_terminal_level <= 1'b1;
        look();
        chk("other func", o_p_gain_pct, 32'sh64);
        @(posedge i_ref_clk);
        i_input_terminal_function <= 8'h03;
        look();
        chk("sec gain", o_p_gain_pct, 32'shC8);
        chk("sec rad", o_p_gain_rad_s, 32'sh7D0);
        @(posedge i_ref_clk);
        i_encoder_vector <= 1'b1;
        look();
        chk("enc rad", o_p_gain_rad_s, 32'shAF0);
        pchk("sec unset", 4'hC, 16'h270F, 1, 32'sh64, 16'h270F);
        pchk("sec time", 4'hD, 16'h0032, 2, 32'sh32, 16'h270F);
        chk("time unset", o_i_time_ms, 32'sh5);
        pchk("gain max", 4'hA, 16'h01F4, 1, 32'sh1F4, 16'h0064);
        pchk("gain over", 4'hA, 16'h01F5, 1, 32'sh64, 16'h0064);
        pchk("time max", 4'hB, 16'h01F4, 2, 32'sh1F4, 16'h0005);
        pchk("time over", 4'hB, 16'h01F5, 2, 32'sh5, 16'h0005);
        $display("test gain done");
        @(posedge i_ref_clk);
        i_limit_source_select <= 1'b0;
        i_start_in <= 1'b1;
        wait_lim("ramp up", 17'sh07530, 100);
        chk("ramp span", cyc >= 18 && cyc <= 40, 32'sh1);
        for (int k = 0; k < 3; k++) begin
            @(posedge i_ref_clk);
            ms <= 3'h1 << k;
            wait_lim("multi speed", 17'sh02710, 300);
            @(posedge i_ref_clk);
            ms <= 3'h0;
            wait_lim("analog back", 17'sh07530, 60);
        end
        @(posedge i_ref_clk);
        i_second_accel_sel <= 1'b1;
        i_start_in <= 1'b0;
        wait_lim("fall", 17'sh007D0, 30);
        wait_lim("idle", 17'sh00000, 10);
        $display("test ramp done");
        summarize();
    end
endmodule : tsl_limiter_tb_top
`default_nettype wire

// ---- bench/tsl_param_store.sv ----
// Parameter store model feeding the speed limiter
`timescale 1ns/1ns
`default_nettype none
`include "tsl_regs.svh"
module tsl_param_store (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_wr,
    input wire logic [3:0] i_idx,
    input wire logic [15:0] i_val,
    output logic [15:0] o_prm [16]
);
    // ----
    // Slots: fwd rev max min start acc dec acc2 dec2 dc p1 i1 p2 i2 cmd ms
    // ----
    localparam logic [15:0] DFLT [16] = '{`TSL_FWD_LIMIT_RST, `TSL_UNSET_CODE,
        `TSL_LIMIT_MAX_HZ_X100, 16'h0000, 16'h0000, 16'h0004, 16'h0028, 16'h0001,
        16'h0001, 16'h07D0, `TSL_PGAIN_RST_PCT, `TSL_ITIME_RST_MS, `TSL_UNSET_CODE,
        `TSL_UNSET_CODE, 16'h7530, 16'h2710};
    // Writes land one edge late, like a real store
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_prm <= DFLT;
        end else if (i_wr) begin
            o_prm[i_idx] <= i_val;
        end
    end
endmodule : tsl_param_store
`default_nettype wire

// ---- src/tsl_gain_select.sv ----
// Current-loop gain set selector
`timescale 1ns/1ns
`default_nettype none
`include "tsl_regs.svh"
module tsl_gain_select (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_second_function_in,
    input wire logic i_encoder_vector,
    input wire logic [15:0] i_current_p_gain_primary,
    input wire logic [15:0] i_current_i_time_primary,
    input wire logic [15:0] i_current_p_gain_secondary,
    input wire logic [15:0] i_current_i_time_secondary,
    output logic [15:0] o_p_gain_pct,
    output logic [15:0] o_i_time_ms,
    output logic [31:0] o_p_gain_rad_s
);
    logic [15:0] p_nxt;
    logic [15:0] i_nxt;
    logic [15:0] p_prim;
    logic [15:0] i_prim;
    logic [15:0] unit;
    logic [31:0] rad_nxt;

    // Out-of-range primary settings fall back to defaults rather than saturate
    assign p_prim = (i_current_p_gain_primary > `TSL_PGAIN_MAX_PCT) ?
        `TSL_PGAIN_RST_PCT : i_current_p_gain_primary;
    assign i_prim = (i_current_i_time_primary > `TSL_ITIME_MAX_MS) ?
        `TSL_ITIME_RST_MS : i_current_i_time_primary;

    always_comb begin
        p_nxt = p_prim;
        i_nxt = i_prim;
        if (i_second_function_in) begin
            if (i_current_p_gain_secondary != `TSL_UNSET_CODE &&
                i_current_p_gain_secondary <= `TSL_PGAIN_MAX_PCT) begin
                p_nxt = i_current_p_gain_secondary;
            end
            if (i_current_i_time_secondary != `TSL_UNSET_CODE &&
                i_current_i_time_secondary <= `TSL_ITIME_MAX_MS) begin
                i_nxt = i_current_i_time_secondary;
            end
        end
    end

    assign unit = i_encoder_vector ? `TSL_PGAIN_UNIT_ENC : `TSL_PGAIN_UNIT_SLV;
    assign rad_nxt = (32'(p_nxt) * 32'(unit)) / 32'(`TSL_PGAIN_SCALE_PCT);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_p_gain_pct <= `TSL_PGAIN_RST_PCT;
            o_i_time_ms <= `TSL_ITIME_RST_MS;
            o_p_gain_rad_s <= (32'(`TSL_PGAIN_RST_PCT) * 32'(`TSL_PGAIN_UNIT_SLV)) /
                32'(`TSL_PGAIN_SCALE_PCT);
        end else begin
            o_p_gain_pct <= p_nxt;
            o_i_time_ms <= i_nxt;
            o_p_gain_rad_s <= rad_nxt;
        end
    end
endmodule : tsl_gain_select
`default_nettype wire

// ---- src/tsl_limiter.sv ----
// Torque-mode speed limiter top
`timescale 1ns/1ns
`default_nettype none
`include "tsl_regs.svh"
// Behaviour
// - Source 0 takes limit target from the speed-control command path.
// - Start on ramps limit from zero up at the acceleration rate.
// - Start off ramps limit down to DC brake start frequency.
// - With source 1, load reversing against torque uses the reverse-side limit.
// - A second accel/decel time pair can replace the primary pair.
// - Limit above maximum frequency becomes maximum frequency.
// - Limit below minimum frequency becomes minimum frequency.
// - Limit below starting frequency becomes zero.
// - Any multi-speed input asserted selects the multi-speed setting.
// - In parameter mode limit sign follows torque except on the reverse side; zero counts positive.
// - Source 1 uses the fixed forward limit parameter.
// - Limit-active shown on panel and limit-active output asserted.
// - Terminal function code 3 gives active-high, 103 active-low.
// - Gain 100 percent is 1000 rad/s sensorless, 1400 with encoder.
// - Primary gain accepts 0 to 500 percent, default 100.
// - Primary integral time accepts 0 to 500 ms, default 5.
// - Second function selects secondary gain unless it holds 9999.
// - Second function selects secondary time unless it holds 9999.
// - Second-function input is the terminal with function code 3.
// - Speed at or beyond limit switches torque to speed regulation.
// - Reverse-side limit 9999 means forward limit serves both sides.
// - Fixed forward and reverse limits accept 0 to 400 Hz.
module tsl_limiter #(
    parameter int TICK_CYCLES = `TSL_TICK_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_b,
    input wire logic i_limit_source_select,
    input wire logic [15:0] i_fixed_forward_limit,
    input wire logic [15:0] i_reverse_side_limit,
    input wire logic [15:0] i_speed_command,
    input wire logic [15:0] i_multispeed_setting,
    input wire logic i_multispeed_high_in,
    input wire logic i_multispeed_mid_in,
    input wire logic i_multispeed_low_in,
    input wire logic i_start_in,
    input wire logic i_second_accel_sel,
    input wire logic [15:0] i_accel_time,
    input wire logic [15:0] i_decel_time,
    input wire logic [15:0] i_accel_time_second,
    input wire logic [15:0] i_decel_time_second,
    input wire logic [15:0] i_dc_brake_start_freq,
    input wire logic [15:0] i_max_frequency,
    input wire logic [15:0] i_min_frequency,
    input wire logic [15:0] i_starting_frequency,
    input wire logic signed [15:0] i_torque_command,
    input wire logic signed [15:0] i_actual_speed,
    input wire logic [7:0] i_output_terminal_function,
    input wire logic [7:0] i_input_terminal_function,
    input wire logic i_input_terminal_level,
    input wire logic i_encoder_vector,
    input wire logic [15:0] i_current_p_gain_primary,
    input wire logic [15:0] i_current_i_time_primary,
    input wire logic [15:0] i_current_p_gain_secondary,
    input wire logic [15:0] i_current_i_time_secondary,
    output logic signed [16:0] o_speed_limit,
    output logic o_limit_active_out,
    output logic o_limit_active_display,
    output logic o_speed_regulation,
    output logic [15:0] o_p_gain_pct,
    output logic [15:0] o_i_time_ms,
    output logic [31:0] o_p_gain_rad_s
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    // Step per tick: full scale divided by ramp time in ticks
    function automatic logic [15:0] ramp_step(input logic [15:0] t_ms);
        logic [31:0] q;
        q = 32'h0;
        if (t_ms == 16'h0000) begin
            q = 32'(`TSL_LIMIT_MAX_HZ_X100);
        end else begin
            q = 32'(`TSL_LIMIT_MAX_HZ_X100) / 32'(t_ms);
            if (q == 32'h0) begin
                q = 32'h1;
            end
        end
        return q[15:0];
    endfunction : ramp_step

    function automatic logic [15:0] range_chk(input logic [15:0] v);
        return (v > `TSL_LIMIT_MAX_HZ_X100) ? `TSL_LIMIT_MAX_HZ_X100 : v;
    endfunction : range_chk

    function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] mx,
                                           input logic [15:0] mn, input logic [15:0] st);
        logic [15:0] r;
        r = v;
        if (r > mx) begin
            r = mx;
        end
        if (r < mn) begin
            r = mn;
        end
        if (v < st) begin
            r = 16'h0000;
        end
        return r;
    endfunction : clamp

    // ----------------------------------------
    // Tick timer
    // ----------------------------------------
    logic [31:0] tick_cnt_r;
    logic tick;
    assign tick = (tick_cnt_r == 32'(TICK_CYCLES - 1));

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            tick_cnt_r <= 32'h0;
        end else if (tick) begin
            tick_cnt_r <= 32'h0;
        end else begin
            tick_cnt_r <= tick_cnt_r + 32'h1;
        end
    end

    // ----------------------------------------
    // Target selection
    // ----------------------------------------
    logic multi_sel;
    logic [15:0] cmd_target;
    logic [15:0] fwd_fixed;
    logic [15:0] rev_fixed;
    assign multi_sel = i_multispeed_high_in | i_multispeed_mid_in | i_multispeed_low_in;
    assign cmd_target = multi_sel ? i_multispeed_setting : i_speed_command;
    assign fwd_fixed = range_chk(i_fixed_forward_limit);
    assign rev_fixed = (i_reverse_side_limit == `TSL_UNSET_CODE) ?
        fwd_fixed : range_chk(i_reverse_side_limit);

    // ----------------------------------------
    // Ramp
    // ----------------------------------------
    tsl_pkg::tsl_ramp_e state_r;
    logic [15:0] level_r;
    logic [15:0] acc_t;
    logic [15:0] dec_t;
    logic [15:0] up_step;
    logic [15:0] dn_step;
    assign acc_t = i_second_accel_sel ? i_accel_time_second : i_accel_time;
    assign dec_t = i_second_accel_sel ? i_decel_time_second : i_decel_time;
    assign up_step = ramp_step(acc_t);
    assign dn_step = ramp_step(dec_t);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            state_r <= tsl_pkg::TSL_IDLE;
        end else begin
            case (state_r)
                tsl_pkg::TSL_IDLE: begin
                    if (i_start_in) begin
                        state_r <= tsl_pkg::TSL_RISE;
                    end
                end
                tsl_pkg::TSL_RISE: begin
                    if (!i_start_in) begin
                        state_r <= tsl_pkg::TSL_FALL;
                    end
                end
                tsl_pkg::TSL_FALL: begin
                    if (i_start_in) begin
                        state_r <= tsl_pkg::TSL_RISE;
                    end else if (level_r <= i_dc_brake_start_freq) begin
                        state_r <= tsl_pkg::TSL_IDLE;
                    end
                end
                default: state_r <= tsl_pkg::TSL_IDLE;
            endcase
        end
    end

    // Level tracks target both ways while running, so set-speed changes also ramp
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            level_r <= 16'h0000;
        end else if (state_r == tsl_pkg::TSL_IDLE) begin
            level_r <= 16'h0000;
        end else if (tick && state_r == tsl_pkg::TSL_RISE) begin
            if (level_r < cmd_target) begin
                level_r <= (cmd_target - level_r > up_step) ?
                    level_r + up_step : cmd_target;
            end else begin
                level_r <= (level_r - cmd_target > dn_step) ?
                    level_r - dn_step : cmd_target;
            end
        end else if (tick && state_r == tsl_pkg::TSL_FALL) begin
            level_r <= (level_r > i_dc_brake_start_freq &&
                        level_r - i_dc_brake_start_freq > dn_step) ?
                level_r - dn_step : i_dc_brake_start_freq;
        end
    end

    // ----------------------------------------
    // Clamp, reverse side and polarity
    // ----------------------------------------
    logic torque_neg;
    logic reversed;
    logic [15:0] fwd_mag;
    logic [15:0] rev_mag;
    logic [15:0] mag;
    logic signed [16:0] limit_nxt;
    logic [15:0] speed_abs;
    logic over;
    assign torque_neg = i_torque_command[15];
    // Load driving rotation against torque polarity
    assign reversed = (i_actual_speed != 16'sh0) && (i_actual_speed[15] != torque_neg);
    assign fwd_mag = clamp((i_limit_source_select == `TSL_SRC_FIXED) ? fwd_fixed : level_r,
                           i_max_frequency, i_min_frequency, i_starting_frequency);
    assign rev_mag = clamp((i_limit_source_select == `TSL_SRC_FIXED) ? rev_fixed : level_r,
                           i_max_frequency, i_min_frequency, i_starting_frequency);
    assign mag = reversed ? rev_mag : fwd_mag;
    // Reverse side opposes torque direction, so sign flips with it
    assign limit_nxt = (torque_neg ^ reversed) ? -$signed({1'b0, mag}) :
        $signed({1'b0, mag});
    assign speed_abs = i_actual_speed[15] ? 16'(-i_actual_speed) : 16'(i_actual_speed);
    assign over = (speed_abs >= mag);

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_speed_limit <= 17'sh0;
        end else begin
            o_speed_limit <= limit_nxt;
        end
    end

    // ----------------------------------------
    // Regulation mode and indications
    // ----------------------------------------
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_speed_regulation <= 1'b0;
        end else begin
            o_speed_regulation <= over;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_limit_active_display <= 1'b0;
        end else begin
            o_limit_active_display <= over;
        end
    end

    // Unassigned terminal stays low so no other function sees a false level
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_limit_active_out <= 1'b0;
        end else begin
            if (i_output_terminal_function == `TSL_OUT_FUNC_POS) begin
                o_limit_active_out <= over;
            end else if (i_output_terminal_function == `TSL_OUT_FUNC_NEG) begin
                o_limit_active_out <= ~over;
            end else begin
                o_limit_active_out <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Current-loop gain set
    // ----------------------------------------
    logic second_fn;
    // Unassigned terminal leaves the secondary set unreachable
    assign second_fn = (i_input_terminal_function == `TSL_IN_FUNC_SECOND) &&
        i_input_terminal_level;

    tsl_gain_select u_gain (
        .i_ref_clk(i_ref_clk),
        .i_rst_b(i_rst_b),
        .i_second_function_in(second_fn),
        .i_encoder_vector(i_encoder_vector),
        .i_current_p_gain_primary(i_current_p_gain_primary),
        .i_current_i_time_primary(i_current_i_time_primary),
        .i_current_p_gain_secondary(i_current_p_gain_secondary),
        .i_current_i_time_secondary(i_current_i_time_secondary),
        .o_p_gain_pct(o_p_gain_pct),
        .o_i_time_ms(o_i_time_ms),
        .o_p_gain_rad_s(o_p_gain_rad_s)
    );
endmodule : tsl_limiter
`default_nettype wire

// ---- src/tsl_pkg.sv ----
// Types for the torque-mode speed limiter
package tsl_pkg;
    typedef logic [15:0] tsl_freq_t;
    typedef enum logic [2:0] {
        TSL_IDLE = 3'b001,
        TSL_RISE = 3'b010,
        TSL_FALL = 3'b100
    } tsl_ramp_e;
endpackage : tsl_pkg

// ---- src/tsl_regs.svh ----
// Constants for the torque-mode speed limiter
`ifndef TSL_REGS_SVH
`define TSL_REGS_SVH
// ----------------------------------------
// Parameter codes and ranges
// ----------------------------------------
`define TSL_SRC_COMMAND 1'h0
`define TSL_SRC_FIXED 1'h1
`define TSL_UNSET_CODE 16'h270F
`define TSL_LIMIT_MAX_HZ_X100 16'h9C40
`define TSL_FWD_LIMIT_RST 16'h1770
`define TSL_PGAIN_MAX_PCT 16'h01F4
`define TSL_PGAIN_RST_PCT 16'h0064
`define TSL_ITIME_MAX_MS 16'h01F4
`define TSL_ITIME_RST_MS 16'h0005
`define TSL_PGAIN_UNIT_SLV 16'h03E8
`define TSL_PGAIN_UNIT_ENC 16'h0578
`define TSL_PGAIN_SCALE_PCT 16'h0064
`define TSL_OUT_FUNC_POS 8'h03
`define TSL_OUT_FUNC_NEG 8'h67
`define TSL_IN_FUNC_SECOND 8'h03
// ----------------------------------------
// Timing
// ----------------------------------------
`define TSL_CLK_HZ 10000000
`define TSL_TICK_US 1000
`define TSL_TICK_CYCLES ((`TSL_CLK_HZ / 1000000) * `TSL_TICK_US)
`define TSL_RAMP_MS_PER_TICK 1
`endif
